// ### common/compare_output_defs.vh
// Purpose: shared offsets, field positions, reset values and mode codes
// Assumes: 8-bit register port, byte addresses
// Notes: definitions only
`ifndef COMPARE_OUTPUT_DEFS_VH
`define COMPARE_OUTPUT_DEFS_VH

// register offsets
`define OFS_CTRL_A 8'h80
`define OFS_CTRL_B 8'h81
`define OFS_COUNT_LO 8'h84
`define OFS_COUNT_HI 8'h85
`define OFS_LIMIT_LO 8'h86
`define OFS_LIMIT_HI 8'h87
`define OFS_MATCH_A_LO 8'h88
`define OFS_MATCH_A_HI 8'h89
`define OFS_MATCH_B_LO 8'h8A
`define OFS_MATCH_B_HI 8'h8B
`define OFS_PORT 8'h8C
`define OFS_STATUS 8'h8D

// control a fields
`define CA_ACT_A_HI 7
`define CA_ACT_A_LO 6
`define CA_ACT_B_HI 5
`define CA_ACT_B_LO 4
`define CA_WAVE_HI 1
`define CA_WAVE_LO 0
`define CA_WRITE_MASK 8'hF3

// control b fields
`define CB_WAVE_HI 4
`define CB_WAVE_LO 3
`define CB_RUN 0
`define CB_WRITE_MASK 8'h19

// port register fields: direction in 1:0, level in 5:4
`define PT_DIR_A 0
`define PT_DIR_B 1
`define PT_LVL_A 4
`define PT_LVL_B 5
`define PT_WRITE_MASK 8'h33

// reset values
`define RST_CTRL_A 8'h00
`define RST_CTRL_B 8'h00
`define RST_PORT 8'h00
`define RST_WORD 16'h0000

// mode classes
`define CLS_NONPWM 2'h0
`define CLS_FAST 2'h1
`define CLS_DUAL 2'h2

// output actions
`define ACT_OFF 2'h0
`define ACT_TOGGLE 2'h1
`define ACT_CLEAR 2'h2
`define ACT_SET 2'h3

// waveform select codes used by name
`define WV_NORMAL 4'h0
`define WV_CTC_A 4'h4
`define WV_FAST_8 4'h5
`define WV_FAST_9 4'h6
`define WV_FAST_10 4'h7
`define WV_DUAL_9 4'h9
`define WV_DUAL_11 4'hB
`define WV_CTC_L 4'hC
`define WV_RSVD 4'hD
`define WV_FAST_14 4'hE
`define WV_FAST_15 4'hF

// fixed count limits
`define TOP_MAX 16'hFFFF
`define TOP_8 16'h00FF
`define TOP_9 16'h01FF
`define TOP_10 16'h03FF

`endif

// ### logic/count_core.v
// Purpose: 16-bit counter, single slope or dual slope
// Assumes: tick is a one-cycle enable on clk
// Notes: top may change at any time; no double buffering
`timescale 1ns/10ps
`include "compare_output_defs.vh"

module count_core (
  clk,
  rst,
  tick,
  cls,
  top,
  count_r,
  down_r
);
  input wire clk;
  input wire rst;
  input wire tick; // advance one step
  input wire [1:0] cls; // mode class
  input wire [15:0] top; // turnaround value
  output reg [15:0] count_r; // counter value
  output reg down_r; // high while counting down

  ////////////////////////////////////////////////////////////////////////
  // step the counter
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      count_r <= `RST_WORD;
      down_r <= 1'b0;
    end else if (tick) begin
      if (cls == `CLS_DUAL) begin
        // a zero top would oscillate, so hold at bottom
        if (top == 16'h0000) begin
          count_r <= 16'h0000;
          down_r <= 1'b0;
        end else if (!down_r && count_r >= top) begin
          down_r <= 1'b1;
          count_r <= count_r - 16'h0001;
        end else if (down_r && count_r == 16'h0000) begin
          down_r <= 1'b0;
          count_r <= 16'h0001;
        end else if (down_r) begin
          count_r <= count_r - 16'h0001;
        end else begin
          count_r <= count_r + 16'h0001;
        end
      end else begin
        // single slope wraps to bottom after top
        down_r <= 1'b0;
        if (count_r >= top) begin
          count_r <= 16'h0000;
        end else begin
          count_r <= count_r + 16'h0001;
        end
      end
    end
  end
endmodule

// ### logic/wave_channel.v
// Purpose: one compare output flip-flop and its action decoding
// Assumes: count, match and top are stable in the tick cycle
// Notes: output holds its level while the channel is disconnected
`timescale 1ns/10ps
`include "compare_output_defs.vh"

module wave_channel (
  clk,
  rst,
  tick,
  cls,
  action,
  toggle_ok,
  count,
  down,
  match_val,
  top,
  level_r
);
  input wire clk;
  input wire rst;
  input wire tick; // counter step enable
  input wire [1:0] cls; // mode class
  input wire [1:0] action; // output action field
  input wire toggle_ok; // toggle allowed in pwm classes
  input wire [15:0] count; // counter value
  input wire down; // counting down
  input wire [15:0] match_val; // compare value
  input wire [15:0] top; // current top
  output reg level_r; // compare output level

  wire hit; // compare match this step
  wire at_bottom; // counter at bottom this step
  wire at_top_val; // compare value equals top
  reg level_nxt;

  assign hit = tick && (count == match_val);
  assign at_bottom = tick && (count == 16'h0000);
  assign at_top_val = (match_val == top);

  ////////////////////////////////////////////////////////////////////////
  // next level per class
  always @* begin
    level_nxt = level_r;
    case (cls)
      `CLS_FAST: begin
        if (action == `ACT_TOGGLE) begin
          if (toggle_ok && hit)
            level_nxt = ~level_r;
        end else if (action[1]) begin
          if (at_bottom)
            level_nxt = ~action[0];
          // ignore match at top; match beats bottom so zero gives a steady match level
          if (hit && !at_top_val)
            level_nxt = action[0];
        end
      end
      `CLS_DUAL: begin
        if (action == `ACT_TOGGLE) begin
          if (toggle_ok && hit)
            level_nxt = ~level_r;
        end else if (action[1]) begin
          // extreme compare values give steady levels
          if (tick && match_val == 16'h0000)
            level_nxt = action[0];
          else if (tick && at_top_val)
            level_nxt = ~action[0];
          else if (hit)
            level_nxt = down ? ~action[0] : action[0];
        end
      end
      default: begin
        // toggle, clear or set on match
        if (hit) begin
          case (action)
            `ACT_TOGGLE: level_nxt = ~level_r;
            `ACT_CLEAR: level_nxt = 1'b0;
            `ACT_SET: level_nxt = 1'b1;
            default: level_nxt = level_r;
          endcase
        end
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // output flip-flop
  always @(posedge clk or posedge rst) begin
    if (rst)
      level_r <= 1'b0;
    else
      level_r <= level_nxt;
  end
endmodule

// ### logic/compare_output_control.v
// Purpose: compare output mode control of a 16-bit timer with two outputs
// Assumes: one clock, register port on the same clock, pins driven directly
// Notes: counter, limit and pin port bits live here so the outputs can be exercised
//
// Contract
// - action a nonzero gives pin a to timer; the code keeps the port for a toggle in pwm codes other than 9, 11, 14, 15
// - action b nonzero gives pin b to timer; the code leaves pin b to the port for a toggle in either pwm class
// - pin driven only when direction bit set
// - action meaning depends on waveform class
// - non-pwm: off, toggle, clear, set on match
// - fast toggle only a, modes 14/15
// - fast: clear/set on match, opposite at bottom
// - fast: match at top ignored, bottom action kept
// - dual toggle only a, modes 9/11
// - dual: action by counting direction
// - four mode bits from both control registers
// - normal, clear-on-match and three pwm modes; the code has two pwm classes, fast and dual
// - dual extremes give steady low or high
//
// Strobed register access is this design's own decision.
`timescale 1ns/10ps
`include "compare_output_defs.vh"

module compare_output_control (
  clk,
  rst,
  reg_addr,
  reg_wdata,
  reg_wr,
  reg_rd,
  reg_rdata,
  match_pin_a_out,
  match_pin_a_oe,
  match_pin_b_out,
  match_pin_b_oe
);
  input wire clk; // 25 MHz timer clock
  input wire rst; // asynchronous, active high
  input wire [7:0] reg_addr; // register byte address
  input wire [7:0] reg_wdata; // write data
  input wire reg_wr; // write strobe
  input wire reg_rd; // read strobe
  output reg [7:0] reg_rdata; // read data, cycle after strobe
  output wire match_pin_a_out; // pin a level
  output wire match_pin_a_oe; // pin a driver enable
  output wire match_pin_b_out; // pin b level
  output wire match_pin_b_oe; // pin b driver enable

  ////////////////////////////////////////////////////////////////////////
  // registers
  // all on the one timer clock, so nothing crosses domains
  reg [7:0] timer_control_a_r; // actions and low mode bits
  reg [7:0] timer_control_b_r; // upper mode bits and run
  reg [15:0] limit_r; // software top for limit modes
  reg [15:0] match_value_a_r; // compare value a
  reg [15:0] match_value_b_r; // compare value b
  reg [7:0] port_r; // pin direction and port level

  ////////////////////////////////////////////////////////////////////////
  // decoded controls
  // decodes here are combinational from the registers; count, down and levels are flip-flop outputs
  wire [1:0] output_action_a; // channel a action
  wire [1:0] output_action_b; // channel b action
  wire [3:0] waveform_select; // combined mode
  wire [1:0] mode_cls; // mode class
  wire [15:0] top_val; // current top
  wire run; // counter enable
  wire [15:0] count; // counter value
  wire down; // counter direction
  wire level_a; // compare output a
  wire level_b; // compare output b
  wire toggle_ok_a; // toggle allowed on a
  wire connect_a; // pin a taken by timer
  wire connect_b; // pin b taken by timer

  ////////////////////////////////////////////////////////////////////////
  // mode class of a waveform code
  function [1:0] class_of;
    input [3:0] m;
    begin
      case (m)
        // normal and clear-on-match modes
        // the reserved code acts as a plain counter
        `WV_NORMAL, `WV_CTC_A, `WV_CTC_L, `WV_RSVD: class_of = `CLS_NONPWM;
        // single-slope pwm codes
        `WV_FAST_8, `WV_FAST_9, `WV_FAST_10, `WV_FAST_14, `WV_FAST_15: class_of = `CLS_FAST;
        // remaining codes count up then down
        default: class_of = `CLS_DUAL;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // top value of a waveform code
  function [15:0] top_of;
    input [3:0] m;
    input [15:0] mva;
    input [15:0] lim;
    begin
      case (m)
        // free-running counter uses the full range
        `WV_NORMAL: top_of = `TOP_MAX;
        // fixed resolutions; codes 1 to 3 are the
        // dual-slope twins of 5 to 7
        4'h1, `WV_FAST_8: top_of = `TOP_8;
        4'h2, `WV_FAST_9: top_of = `TOP_9;
        4'h3, `WV_FAST_10: top_of = `TOP_10;
        // compare a sets the period, so a loses its duty
        `WV_CTC_A, `WV_DUAL_9, `WV_DUAL_11, `WV_FAST_15: top_of = mva;
        // the rest take the limit register
        default: top_of = lim;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // byte merge for 16-bit registers
  function [15:0] put_byte;
    input [15:0] old;
    input hi;
    input [7:0] b;
    begin
      // each byte lands at once; an atomic 16-bit
      // update needs the counter stopped first
      if (hi)
        // upper byte replaced
        put_byte = {b, old[7:0]};
      else
        // lower byte replaced
        put_byte = {old[15:8], b};
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // field decoding
  // action fields straight from control a
  assign output_action_a = timer_control_a_r[`CA_ACT_A_HI:`CA_ACT_A_LO];
  assign output_action_b = timer_control_a_r[`CA_ACT_B_HI:`CA_ACT_B_LO];

  assign waveform_select = {timer_control_b_r[`CB_WAVE_HI:`CB_WAVE_LO],
                            timer_control_a_r[`CA_WAVE_HI:`CA_WAVE_LO]};
  assign mode_cls = class_of(waveform_select);
  // top follows its source at once, no double buffer
  assign top_val = top_of(waveform_select, match_value_a_r, limit_r);
  // no prescaler: one step per clock while run is set
  assign run = timer_control_b_r[`CB_RUN];

  // toggle codes, fast and dual
  // a toggle on a is allowed only in codes 14, 15, 9 and 11
  assign toggle_ok_a = (waveform_select == `WV_FAST_14) || (waveform_select == `WV_FAST_15) ||
                       (waveform_select == `WV_DUAL_9) || (waveform_select == `WV_DUAL_11);

  ////////////////////////////////////////////////////////////////////////
  // register writes
  // unmapped addresses and reserved bits drop silently
  // reserved bits masked, zero reset
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      // every register starts at zero
      timer_control_a_r <= `RST_CTRL_A;
      timer_control_b_r <= `RST_CTRL_B;
      limit_r <= `RST_WORD;
      match_value_a_r <= `RST_WORD;
      match_value_b_r <= `RST_WORD;
      port_r <= `RST_PORT;
    end else if (reg_wr) begin
      // one register per strobe, never a wait state
      case (reg_addr)
        // control a: bits 3:2 never stored
        `OFS_CTRL_A: timer_control_a_r <= reg_wdata & `CA_WRITE_MASK;
        // control b: upper mode bits and run only
        `OFS_CTRL_B: timer_control_b_r <= reg_wdata & `CB_WRITE_MASK;
        // limit bytes, top of the limit codes
        `OFS_LIMIT_LO: limit_r <= put_byte(limit_r, 1'b0, reg_wdata);
        `OFS_LIMIT_HI: limit_r <= put_byte(limit_r, 1'b1, reg_wdata);
        // compare a, also top for some codes
        `OFS_MATCH_A_LO: match_value_a_r <= put_byte(match_value_a_r, 1'b0, reg_wdata);
        `OFS_MATCH_A_HI: match_value_a_r <= put_byte(match_value_a_r, 1'b1, reg_wdata);
        // compare b
        `OFS_MATCH_B_LO: match_value_b_r <= put_byte(match_value_b_r, 1'b0, reg_wdata);
        `OFS_MATCH_B_HI: match_value_b_r <= put_byte(match_value_b_r, 1'b1, reg_wdata);
        // port: direction and idle level of both pins
        `OFS_PORT: port_r <= reg_wdata & `PT_WRITE_MASK;
        // unmapped writes are dropped
        default: port_r <= port_r;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // register reads, answered in the following cycle only
  // a read has no side effect on any register
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      // stored masks keep reserved bits at zero
      case (reg_addr)
        // control registers
        `OFS_CTRL_A: reg_rdata <= timer_control_a_r;
        `OFS_CTRL_B: reg_rdata <= timer_control_b_r;
        // live count; bytes of a running count may tear
        `OFS_COUNT_LO: reg_rdata <= count[7:0];
        `OFS_COUNT_HI: reg_rdata <= count[15:8];
        // limit
        `OFS_LIMIT_LO: reg_rdata <= limit_r[7:0];
        `OFS_LIMIT_HI: reg_rdata <= limit_r[15:8];
        // compare a
        `OFS_MATCH_A_LO: reg_rdata <= match_value_a_r[7:0];
        `OFS_MATCH_A_HI: reg_rdata <= match_value_a_r[15:8];
        // compare b
        `OFS_MATCH_B_LO: reg_rdata <= match_value_b_r[7:0];
        `OFS_MATCH_B_HI: reg_rdata <= match_value_b_r[15:8];
        // port
        `OFS_PORT: reg_rdata <= port_r;
        // live state: levels, direction, connections
        // shows the wave level even while a pin shows the port
        `OFS_STATUS: reg_rdata <= {3'h0, connect_b, connect_a, down, level_b, level_a};
        // holes in the map read as zero
        default: reg_rdata <= 8'h00;
      endcase
    end else begin
      // data stands for one cycle only
      reg_rdata <= 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // counter
  // top may move under a running count
  count_core u_count (
    .clk(clk),
    .rst(rst),
    .tick(run),
    .cls(mode_cls),
    .top(top_val),
    .count_r(count),
    .down_r(down)
  );

  ////////////////////////////////////////////////////////////////////////
  // channel a, may toggle in pwm classes
  // both channels share the counter and its step
  wave_channel u_chan_a (
    .clk(clk),
    .rst(rst),
    .tick(run),
    .cls(mode_cls),
    .action(output_action_a),
    // toggle permission depends on the mode code
    .toggle_ok(toggle_ok_a),
    .count(count),
    .down(down),
    .match_val(match_value_a_r),
    .top(top_val),
    .level_r(level_a)
  );

  ////////////////////////////////////////////////////////////////////////
  // channel b, never toggles in pwm classes
  // b sets no top of its own, so a toggle is of no use
  // with a toggle code in the pwm classes b stays disconnected
  wave_channel u_chan_b (
    .clk(clk),
    .rst(rst),
    .tick(run),
    .cls(mode_cls),
    .action(output_action_b),
    // never allowed to toggle in the pwm classes
    .toggle_ok(1'b0),
    .count(count),
    .down(down),
    .match_val(match_value_b_r),
    .top(top_val),
    .level_r(level_b)
  );

  ////////////////////////////////////////////////////////////////////////
  // pin override; a toggle code that is not allowed leaves the pin to the port
  // channel a override
  assign connect_a = (output_action_a != `ACT_OFF) &&
                     !(output_action_a == `ACT_TOGGLE && mode_cls != `CLS_NONPWM && !toggle_ok_a);
  assign connect_b = (output_action_b != `ACT_OFF) &&
                     !(output_action_b == `ACT_TOGGLE && mode_cls != `CLS_NONPWM);


  ////////////////////////////////////////////////////////////////////////
  // pin levels
  // a disconnected pin shows the port level; the wave flip-flop
  // keeps its state, so reconnecting shows the last wave level
  assign match_pin_a_out = connect_a ? level_a : port_r[`PT_LVL_A];
  assign match_pin_b_out = connect_b ? level_b : port_r[`PT_LVL_B];

  ////////////////////////////////////////////////////////////////////////
  // pin drivers
  // the timer never enables a driver by itself
  // direction bit gates the driver
  assign match_pin_a_oe = port_r[`PT_DIR_A];
  assign match_pin_b_oe = port_r[`PT_DIR_B];
endmodule

// ### tb/compare_output_sva.sv
// Purpose: port checker for the compare output control block
// Assumes: mirrors below follow register writes on the same edge as the design
// Notes: pin levels are combinational from registers, so the disconnect and toggle checks use |->
`timescale 1ns/10ps
`include "compare_output_defs.vh"
module compare_output_sva (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic match_pin_a_out,
  input wire logic match_pin_a_oe,
  input wire logic match_pin_b_out,
  input wire logic match_pin_b_oe
);
  reg [7:0] ca_r; // control a mirror
  reg [7:0] cb_r; // control b mirror
  reg [7:0] pt_r; // port register mirror
  wire [3:0] mode = {cb_r[4:3], ca_r[1:0]};
  wire fast = (mode[3:2] == 2'h1 && mode[1:0] != 2'h0) || mode[3:1] == 3'h7;
  wire dual = (mode[3:2] == 2'h0 && mode != 4'h0) || mode[3:2] == 2'h2;
  ////////////////////////////////////////////////////////////
  // mirror writable bits, masked as the device masks them
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      ca_r <= 8'h00;
      cb_r <= 8'h00;
      pt_r <= 8'h00;
    end else if (reg_wr) begin
      if (reg_addr == `OFS_CTRL_A) ca_r <= reg_wdata & `CA_WRITE_MASK;
      if (reg_addr == `OFS_CTRL_B) cb_r <= reg_wdata & `CB_WRITE_MASK;
      if (reg_addr == `OFS_PORT) pt_r <= reg_wdata & `PT_WRITE_MASK;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////
  sequence s_wr_a; reg_wr && reg_addr == `OFS_CTRL_A; endsequence
  sequence s_rd_a; reg_rd && reg_addr == `OFS_CTRL_A; endsequence
  property p_resv; s_wr_a ##2 s_rd_a |=> reg_rdata == ($past(reg_wdata, 3) & `CA_WRITE_MASK); endproperty
  a_resv: assert property (p_resv) else $error("control a readback wrong");
  property p_unmapped; reg_rd && reg_addr[7:4] != 4'h8 |=> reg_rdata == 8'h00; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_oe;
    reg_wr && reg_addr == `OFS_PORT |=> match_pin_a_oe == $past(reg_wdata[0]) && match_pin_b_oe == $past(reg_wdata[1]);
  endproperty
  a_oe: assert property (p_oe) else $error("driver enable not from direction");
  property p_oe_hold; !(reg_wr && reg_addr == `OFS_PORT) |=> $stable(match_pin_a_oe) && $stable(match_pin_b_oe); endproperty
  a_oe_hold: assert property (p_oe_hold) else $error("driver enable moved");
  property p_disc_a; ca_r[7:6] == `ACT_OFF |-> match_pin_a_out == pt_r[`PT_LVL_A]; endproperty
  a_disc_a: assert property (p_disc_a) else $error("pin a not port level");
  property p_disc_b; ca_r[5:4] == `ACT_OFF |-> match_pin_b_out == pt_r[`PT_LVL_B]; endproperty
  a_disc_b: assert property (p_disc_b) else $error("pin b not port level");
  property p_tog_a;
    ca_r[7:6] == `ACT_TOGGLE && ((fast && mode[3:1] != 3'h7) || (dual && mode != 4'h9 && mode != 4'hB))
      |-> match_pin_a_out == pt_r[`PT_LVL_A];
  endproperty
  a_tog_a: assert property (p_tog_a) else $error("pin a toggle not refused");
  property p_tog_b; ca_r[5:4] == `ACT_TOGGLE && (fast || dual) |-> match_pin_b_out == pt_r[`PT_LVL_B]; endproperty
  a_tog_b: assert property (p_tog_b) else $error("pin b toggle not refused");
  property p_clr_hold; !fast && !dual && ca_r[7:6] == `ACT_CLEAR && !match_pin_a_out && !reg_wr |=> !match_pin_a_out;
  endproperty
  a_clr_hold: assert property (p_clr_hold) else $error("clear action raised pin a");
  property p_set_hold; !fast && !dual && ca_r[7:6] == `ACT_SET && match_pin_a_out && !reg_wr |=> match_pin_a_out;
  endproperty
  a_set_hold: assert property (p_set_hold) else $error("set action lowered pin a");
endmodule

// ### tb/pin_load.sv
// Purpose: load on one compare pin
// Assumes: weak pull-down on the board net
// Notes: an undriven pin reads low, never its last level
`timescale 1ns/10ps
module pin_load (
  input wire logic drv,
  input wire logic oe,
  output logic level
);
  assign level = oe ? drv : 1'b0;
endmodule

// ### tb/testbench.sv
// Purpose: self-checking bench for compare output control
// Assumes: duty is counted over whole output periods after settling
// Notes: each case restarts from reset so the counter starts at zero
`timescale 1ns/10ps
`include "compare_output_defs.vh"
module testbench;
  logic clk, rst, reg_wr, reg_rd;
  logic [7:0] reg_addr, reg_wdata;
  logic [31:0] seed;
  wire [7:0] reg_rdata;
  wire pa_out, pa_oe, pb_out, pb_oe, lvl_a, lvl_b;
  int n_errors, check_count;
  compare_output_control uut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .match_pin_a_out(pa_out),
    .match_pin_a_oe(pa_oe), .match_pin_b_out(pb_out), .match_pin_b_oe(pb_oe));
  pin_load load_a (.drv(pa_out), .oe(pa_oe), .level(lvl_a));
  pin_load load_b (.drv(pb_out), .oe(pb_oe), .level(lvl_b));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], 1'b0} ^ (s[31] ? 32'h04C11DB7 : 32'h0);
  endfunction
  // expected high cycles of a pin over w cycles
  function automatic int exp_high(input int ch, input int mode, input int act, input int m, input int top,
      input int lvl, input int oe, input int w);
    int cls;
    int h;
    cls = (mode inside {5, 6, 7, 14, 15}) ? 1 : (mode inside {1, 2, 3, 8, 9, 10, 11}) ? 2 : 0;
    if (oe == 0) return 0;
    if (act == 0 || (act == 1 && cls != 0 && (ch == 1 || !(mode inside {9, 11, 14, 15})))) return lvl * w;
    if (act == 1) return w / 2;
    if (cls == 0) return (act == 3) ? w : 0;
    if (cls == 1 && m != top) h = m * w / (top + 1);
    else if (cls == 1 || m == top) h = w;
    // high below the compare value on both slopes
    else h = m * w / top;
    return (act == 3) ? w - h : h;
  endfunction
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic conclude;
    if (n_errors == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string name);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    check(name, {8'h00, reg_rdata}, {8'h00, exp});
  endtask
  // reset, configure, run, then count high cycles on both pins
  task automatic run_case(input logic [3:0] mode, input logic [1:0] aa, input logic [1:0] ab,
      input logic [15:0] ma, input logic [15:0] mb, input logic [15:0] lim, input logic [7:0] pt, input int w);
    int ha;
    int hb;
    int top;
    @(posedge clk);
    rst <= 1'b1;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    wr(`OFS_CTRL_A, {aa, ab, 2'b11, mode[1:0]});
    rd(`OFS_CTRL_A, {aa, ab, 2'b00, mode[1:0]}, "control a");
    wr(`OFS_LIMIT_LO, lim[7:0]);
    wr(`OFS_LIMIT_HI, lim[15:8]);
    wr(`OFS_MATCH_A_LO, ma[7:0]);
    wr(`OFS_MATCH_A_HI, ma[15:8]);
    wr(`OFS_MATCH_B_LO, mb[7:0]);
    wr(`OFS_MATCH_B_HI, mb[15:8]);
    wr(`OFS_PORT, pt);
    wr(`OFS_CTRL_B, {3'b000, mode[3:2], 3'b001});
    top = (mode inside {4'h8, 4'hE}) ? lim : (mode == 4'h1 || mode == 4'h5) ? 255 : ma;
    repeat (600) @(posedge clk);
    ha = 0;
    hb = 0;
    repeat (w) begin
      @(negedge clk);
      if (lvl_a === 1'b1) ha++;
      if (lvl_b === 1'b1) hb++;
    end
    check("pin a high", 16'(ha), 16'(exp_high(0, mode, aa, ma, top, pt[4], pt[0], w)));
    check("pin b high", 16'(hb), 16'(exp_high(1, mode, ab, mb, top, pt[5], pt[1], w)));
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (60000) @(posedge clk);
    n_errors++;
    conclude();
  end
  initial begin
    rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    n_errors = 0;
    check_count = 0;
    seed = 32'h1d0da940;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rd(`OFS_CTRL_A, 8'h00, "control a reset");
    rd(`OFS_CTRL_B, 8'h00, "control b reset");
    wr(8'h90, 8'hFF);
    rd(8'h90, 8'h00, "unmapped");
    repeat (4) begin
      seed = lfsr(seed);
      wr(`OFS_CTRL_A, seed[7:0]);
      rd(`OFS_CTRL_A, seed[7:0] & `CA_WRITE_MASK, "control a readback");
    end
    for (int k = 0; k < 4; k++) run_case(`WV_CTC_A, k[1:0], k[1:0], 16'h9, 16'h5, 16'h0, 8'h33, 720);
    run_case(`WV_CTC_A, 2'h3, 2'h3, 16'h9, 16'h5, 16'h0, 8'h00, 720);
    for (int k = 2; k < 4; k++) begin
      seed = lfsr(seed);
      run_case(`WV_FAST_8, k[1:0], k[1:0], {8'h00, seed[7:0]}, {8'h00, seed[15:8]}, 16'h0, 8'h03, 512);
    end
    run_case(`WV_FAST_15, 2'h1, 2'h1, 16'h9, 16'h3, 16'h0, 8'h23, 720);
    run_case(`WV_FAST_14, 2'h2, 2'h3, 16'h9, 16'h9, 16'h9, 8'h03, 720);
    for (int k = 2; k < 4; k++) run_case(4'h1, k[1:0], k[1:0], 16'h0, 16'hFF, 16'h0, 8'h03, 720);
    run_case(`WV_DUAL_9, 2'h1, 2'h1, 16'h9, 16'h3, 16'h0, 8'h13, 720);
    run_case(4'h1, 2'h1, 2'h1, 16'h9, 16'h9, 16'h0, 8'h33, 720);
    run_case(4'h8, 2'h2, 2'h3, 16'h10, 16'h8, 16'h20, 8'h03, 128);
    conclude();
  end
endmodule
bind compare_output_control compare_output_sva sva_i (.clk(clk), .rst(rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .match_pin_a_out(match_pin_a_out), .match_pin_a_oe(match_pin_a_oe),
  .match_pin_b_out(match_pin_b_out), .match_pin_b_oe(match_pin_b_oe));
